/* bench/rsa_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
// Behavioural bus master: open-drain data, clock stands high between frames
module rsa_bus_master #(
    parameter int PHASE = 10 // System clocks per bus clock phase
) (
    input wire logic mclk,     // System clock
    input wire logic sda_line, // Resolved data wire
    output logic scl,          // Bus clock, high when idle
    output logic sda_low       // High pulls the data wire low
);
    // Bus released at time zero
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Wait a number of system clocks
    task automatic pause(input int n);
        repeat (n) @(posedge mclk);
    endtask : pause
    // Start or repeated start: data falls while the clock is high
    task automatic start_cond();
        sda_low <= 1'b0;
        pause(PHASE);
        scl <= 1'b1;
        pause(PHASE);
        sda_low <= 1'b1;
        pause(PHASE);
        scl <= 1'b0;
        pause(2);
    endtask : start_cond
    // Stop: data rises while the clock is high, then all is released
    task automatic stop_cond();
        sda_low <= 1'b1;
        pause(PHASE);
        scl <= 1'b1;
        pause(PHASE);
        sda_low <= 1'b0;
        pause(PHASE);
    endtask : stop_cond
    // One bit: data set in the low phase, sampled late in the high phase
    task automatic bit_io(input logic b, output logic s);
        sda_low <= ~b;
        pause(PHASE);
        scl <= 1'b1;
        pause(PHASE);
        s = sda_line;
        scl <= 1'b0;
        pause(2);
    endtask : bit_io
    // Byte out, MSB first; ack is high when the ninth bit was pulled low
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = ~s;
    endtask : send_byte
    // no-ack ends read
    // Byte in, MSB first; ninth bit pulled low only when more data is wanted
    task automatic read_byte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(~more, s);
    endtask : read_byte
endmodule : rsa_bus_master
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Bench: bus master model against the serial access block
module tb_top;
    import rsa_pkg::*;
    localparam int TB_NV_CYC = 2000; // Shortened write cycle, longer than one poll
    localparam int LIMIT = 60000; // Cycle ceiling, about twice the run
    localparam logic [7:0] DEC_ADDR [7] = '{8'hAE, 8'hDE, 8'hA0, 8'hBE, 8'hAC, 8'h2E, 8'hD2};
    localparam logic [6:0] DEC_ACK = 7'h03; // Bit i: address i is acknowledged
    logic mclk;
    logic arst_n;
    logic [7:0] protect_map;
    logic scl;
    logic m_sda_low;
    logic sda_out;
    logic sda_oe;
    logic nv_busy;
    logic sda_line;
    logic ack;
    logic [7:0] d;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Clock and time-zero inputs
    initial begin
        mclk = 1'b0;
        arst_n = 1'b0;
        protect_map = 8'h00;
    end
    always #25 mclk = ~mclk;
    // Open-drain data wire with pull-up
    assign sda_line = ~((sda_oe & ~sda_out) | m_sda_low);
    rsa_serial_access #(.NV_CYC(TB_NV_CYC)) u_dut (
        .mclk(mclk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .protect_map(protect_map), .nv_busy(nv_busy)
    );
    rsa_bus_master u_master (.mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_low(m_sda_low));
    // Compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : check
    // Closing report
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // Send a byte and judge the acknowledge
    task automatic put(input logic [7:0] b, input logic exp_ack);
        u_master.send_byte(b, ack);
        check({7'h00, ack}, {7'h00, exp_ack});
    endtask : put
    // Read a byte and judge it
    task automatic get(input logic more, input logic [7:0] exp);
        u_master.read_byte(more, d);
        check(d, exp);
    endtask : get
    // Dummy write then read start at a word address
    task automatic aim_read(input logic [7:0] sa, input logic [7:0] hi, input logic [7:0] lo);
        u_master.start_cond();
        put(sa, 1'b1);
        put(hi, 1'b1);
        put(lo, 1'b1);
        u_master.start_cond();
        put(sa | 8'h01, 1'b1);
    endtask : aim_read
    // Wait out a write cycle, bounded
    task automatic wait_nv();
        for (int n = 0; n < TB_NV_CYC + 100 && nv_busy; n++) begin
            u_master.pause(1);
        end
        check({7'h00, nv_busy}, 8'h00);
    endtask : wait_nv
    // One byte written to the register space
    task automatic reg_write(input logic [7:0] lo, input logic [7:0] v);
        u_master.start_cond();
        put(8'hDE, 1'b1);
        put(8'h00, 1'b1);
        put(lo, 1'b1);
        put(v, 1'b1);
        u_master.stop_cond();
        u_master.pause(5);
    endtask : reg_write
    // Address decode, mismatch ignore, early stop
    task automatic t_decode();
        for (int i = 0; i < 7; i++) begin
            u_master.start_cond();
            put(DEC_ADDR[i], DEC_ACK[i]);
            if (!DEC_ACK[i]) begin
                put(8'hAE, 1'b0);
            end
            u_master.stop_cond();
        end
        check({7'h00, nv_busy}, 8'h00);
    endtask : t_decode
    // Page write with wrap and overrun, then polling
    task automatic t_page_write();
        u_master.start_cond();
        put(8'hAE, 1'b1);
        put(8'h00, 1'b1);
        put(8'h00, 1'b1);
        for (int k = 0; k < 18; k++) begin
            put(8'(8'h10 + k), 1'b1);
        end
        u_master.stop_cond();
        u_master.pause(5);
        check({7'h00, nv_busy}, 8'h01);
        u_master.start_cond();
        put(8'hAE, 1'b0);
        u_master.stop_cond();
        wait_nv();
        u_master.pause(5);
        u_master.start_cond();
        put(8'hAE, 1'b1);
        u_master.stop_cond();
    endtask : t_page_write
    // Sequential read of the written page
    task automatic t_seq_read();
        aim_read(8'hAE, 8'h00, 8'h00);
        for (int k = 0; k < 16; k++) begin
            get(k < 15, (k < 2) ? 8'(8'h20 + k) : 8'(8'h10 + k));
        end
        u_master.stop_cond();
    endtask : t_seq_read
    // Set address by stop, then wrap at the end of the space
    task automatic t_set_addr();
        u_master.start_cond();
        put(8'hAE, 1'b1);
        put(8'h01, 1'b1);
        put(8'hFF, 1'b1);
        u_master.stop_cond();
        u_master.pause(5);
        check({7'h00, nv_busy}, 8'h00);
        u_master.start_cond();
        put(8'hAF, 1'b1);
        u_master.read_byte(1'b1, d);
        get(1'b0, 8'h20);
        u_master.stop_cond();
        u_master.start_cond();
        put(8'hAF, 1'b1);
        get(1'b0, 8'h21);
        u_master.stop_cond();
    endtask : t_set_addr
    // Protected write: acknowledged, nothing stored, no write cycle
    task automatic t_protect();
        protect_map <= 8'h01;
        u_master.start_cond();
        put(8'hAE, 1'b1);
        put(8'h00, 1'b1);
        put(8'h05, 1'b1);
        put(8'hEE, 1'b1);
        u_master.stop_cond();
        u_master.pause(5);
        check({7'h00, nv_busy}, 8'h00);
        u_master.start_cond();
        put(8'hAE, 1'b1);
        u_master.stop_cond();
        protect_map <= 8'h00;
        aim_read(8'hAE, 8'h00, 8'h05);
        get(1'b0, 8'h15);
        u_master.stop_cond();
    endtask : t_protect
    // Register space: locked, unlock pair, alarm and time guards, read back
    task automatic t_regs();
        reg_write(8'h00, 8'hA5);
        check({7'h00, nv_busy}, 8'h00);
        // unlock pair stored to status first
        reg_write(8'h3F, 8'h02);
        check({7'h00, nv_busy}, 8'h01);
        wait_nv();
        reg_write(8'h3F, 8'h06);
        check({7'h00, nv_busy}, 8'h01);
        wait_nv();
        reg_write(8'h06, 8'hC3);
        check({7'h00, nv_busy}, 8'h00);
        reg_write(8'h30, 8'h11);
        check({7'h00, nv_busy}, 8'h00);
        reg_write(8'h00, 8'h5A);
        check({7'h00, nv_busy}, 8'h01);
        wait_nv();
        aim_read(8'hDE, 8'h00, 8'h00);
        get(1'b0, 8'h5A);
        u_master.stop_cond();
    endtask : t_regs
    // Second reset: counter back to location zero
    task automatic t_power_up();
        arst_n <= 1'b0;
        u_master.pause(3);
        arst_n <= 1'b1;
        u_master.pause(5);
        u_master.start_cond();
        put(8'hAF, 1'b1);
        get(1'b0, 8'h20);
        u_master.stop_cond();
    endtask : t_power_up
    // Main sequence
    initial begin
        u_master.pause(20);
        arst_n <= 1'b1;
        u_master.pause(5);
        t_decode();
        t_page_write();
        t_seq_read();
        t_set_addr();
        t_protect();
        t_regs();
        t_power_up();
        report_and_stop();
    end
    // Hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            bad_count++;
            report_and_stop();
        end
    end
endmodule : tb_top
`default_nettype wire

/* verilog/rsa_nv_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Nonvolatile write cycle timer, busy while counting
module rsa_nv_timer #(
    parameter int CYCLES = rsa_pkg::NV_WRITE_CYC // Write cycle length
) (
    input wire logic mclk,   // System clock
    input wire logic arst_n, // Async reset
    input wire logic start,  // Launch pulse
    output logic busy        // Write in progress
);
    import rsa_pkg::*;
    logic [23:0] cnt_q;
    // Load on start, count down to zero
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 24'h000000;
        end else if (start) begin
            cnt_q <= 24'(CYCLES);
        end else if (cnt_q != 24'h000000) begin
            cnt_q <= cnt_q - 24'h000001;
        end
    end
    assign busy = (cnt_q != 24'h000000);
endmodule : rsa_nv_timer
`default_nettype wire

/* verilog/rsa_pkg.sv */
package rsa_pkg;
    // Slave address fields
    localparam logic [3:0] ARRAY_ID = 4'hA;      // 1010 selects memory array
    localparam logic [3:0] REGS_ID = 4'hD;       // 1101 selects register space
    localparam logic [2:0] DEV_SEL = 3'h7;       // Device select field 111
    // Address space sizes
    localparam int ARRAY_AW = 9;                 // 512 bytes of array
    localparam int REGS_AW = 6;                  // 64 bytes of register space
    localparam int ARRAY_PAGE_W = 4;             // 16-byte array page
    localparam int REGS_PAGE_W = 3;              // 8-byte register section
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    // Unlock sequence on the status register
    localparam logic [5:0] STATUS_ADDR = 6'h3F;
    localparam logic [7:0] UNLOCK_1 = 8'h02;
    localparam logic [7:0] UNLOCK_2 = 8'h06;
    // Weekday alarm register offsets
    localparam logic [5:0] ALARM_WEEKDAY_0 = 6'h06;
    localparam logic [5:0] ALARM_WEEKDAY_1 = 6'h0E;
    // Time register section (full page only)
    localparam logic [5:0] TIME_BASE = 6'h30;
    localparam int PAGE_BYTES_REGS = 8;
    // Nonvolatile write time
    localparam int CLK_MHZ = 20;
    localparam int NV_WRITE_US = 12000;
    localparam int NV_WRITE_CYC = NV_WRITE_US * CLK_MHZ;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_WADDR_HI, ST_WADDR_LO, ST_WDATA, ST_RDATA, ST_RACK
    } rsa_state_type;
endpackage : rsa_pkg

/* verilog/rsa_serial_access.sv */
`timescale 1ns/1ps
`default_nettype none
module rsa_serial_access #(
    parameter int NV_CYC = rsa_pkg::NV_WRITE_CYC // Write cycle length in clocks
) (
    input wire logic mclk,             // 20 MHz system clock
    input wire logic arst_n,           // Async reset, active low
    input wire logic scl_in,           // Serial clock pin
    input wire logic sda_in,           // Serial data pin level
    output logic sda_out,              // Data drive value (always low)
    output logic sda_oe,               // Data drive enable, high pulls low
    input wire logic [7:0] protect_map, // Protected array blocks, one per 64 bytes
    output logic nv_busy               // Nonvolatile write in progress
);
    import rsa_pkg::*;

    logic scl_s, sda_s, scl_p_q, sda_p_q;
    logic [7:0] array_mem [0:(1 << ARRAY_AW) - 1];
    logic [7:0] regs_mem [0:(1 << REGS_AW) - 1];
    logic [7:0] pbuf [0:15];
    logic [15:0] pvalid_q;
    rsa_state_type state_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [15:0] addr_q;
    logic [15:0] wbase_q;
    logic regs_sel_q;
    logic ack_phase_q;
    logic [4:0] nbytes_q;
    logic wl_step_q;
    logic data_ack_q;
    logic sda_oe_q;
    logic nv_start_q;
    logic busy;

    rsa_sync u_sync_scl (.mclk(mclk), .arst_n(arst_n), .din(scl_in), .dout(scl_s));
    rsa_sync u_sync_sda (.mclk(mclk), .arst_n(arst_n), .din(sda_in), .dout(sda_s));

    rsa_nv_timer #(.CYCLES(NV_CYC)) u_timer (.mclk(mclk), .arst_n(arst_n),
        .start(nv_start_q), .busy(busy));

    // Previous synchronised levels for edge detection
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // Bus events
    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
    wire [7:0] byte_in = {sh_q[6:0], sda_s};

    wire id_array = (sh_q[7:4] == ARRAY_ID);
    wire id_regs = (sh_q[7:4] == REGS_ID);
    wire sel_ok = (sh_q[3:1] == DEV_SEL);
    // full seven-bit compare, no answer while busy
    wire addr_match = (id_array | id_regs) & sel_ok & ~busy;

    // In-page increment of the write address
    function automatic logic [15:0] page_inc(input logic [15:0] a, input logic regs);
        logic [15:0] r;
        r = a;
        if (regs) begin
            r[REGS_PAGE_W-1:0] = a[REGS_PAGE_W-1:0] + 3'h1;
        end else begin
            r[ARRAY_PAGE_W-1:0] = a[ARRAY_PAGE_W-1:0] + 4'h1;
        end
        return r;
    endfunction : page_inc

    // Whole-space increment for reads
    function automatic logic [15:0] seq_inc(input logic [15:0] a, input logic regs);
        logic [15:0] r;
        r = 16'h0000;
        if (regs) begin
            r[REGS_AW-1:0] = a[REGS_AW-1:0] + 6'h01;
        end else begin
            r[ARRAY_AW-1:0] = a[ARRAY_AW-1:0] + 9'h001;
        end
        return r;
    endfunction : seq_inc

    wire [4:0] page_len = regs_sel_q ? 5'h08 : 5'h10;
    wire [3:0] slot = regs_sel_q ? {1'b0, addr_q[2:0]} : addr_q[3:0];
    wire [7:0] rd_byte = regs_sel_q ? regs_mem[addr_q[REGS_AW-1:0]]
                                    : array_mem[addr_q[ARRAY_AW-1:0]];
    // Next read location, so a continued read starts on the new byte
    wire [15:0] nxt_addr = seq_inc(addr_q, regs_sel_q);
    wire [7:0] rd_next = regs_sel_q ? regs_mem[nxt_addr[REGS_AW-1:0]]
                                    : array_mem[nxt_addr[ARRAY_AW-1:0]];
    // Register offset of the last byte written, for store checks
    wire [5:0] wlast = wbase_q[5:0];
    wire prot_hit = ~regs_sel_q & protect_map[wbase_q[8:6]];
    // register writes other than to status locked until unlock pair seen
    wire wr_unlocked = (wl_step_q == 1'b1);
    wire is_status = regs_sel_q & (wlast == STATUS_ADDR);
    // New status value waiting in the page buffer
    wire [7:0] status_new = pbuf[STATUS_ADDR[2:0]];
    // lone weekday alarm byte stores nothing
    wire alarm_single = regs_sel_q & (nbytes_q == 5'h01)
                        & ((wlast == ALARM_WEEKDAY_0) | (wlast == ALARM_WEEKDAY_1));
    // time section needs a full page
    wire time_short = regs_sel_q & (wlast[5:3] == TIME_BASE[5:3])
                      & (nbytes_q < 5'(PAGE_BYTES_REGS));
    // at least one acknowledged data byte; the stop's own clock rise
    // shifts one bit in, so a clean stop is seen with one bit counted
    wire have_data = (state_q == ST_WDATA) & (nbytes_q != 5'h00) & (bit_q <= 4'h1)
                     & ~ack_phase_q;
    wire do_commit = have_data & ~prot_hit & ~alarm_single & ~time_short
                     & (~regs_sel_q | wr_unlocked | is_status);

    logic wl_q;
    assign wl_step_q = wl_q;
    logic [7:0] last_status_q;

    // Main serial state machine
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            addr_q <= ADDR_RESET;
            wbase_q <= ADDR_RESET;
            regs_sel_q <= 1'b0;
            ack_phase_q <= 1'b0;
            nbytes_q <= 5'h00;
            pvalid_q <= 16'h0000;
            data_ack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            nv_start_q <= 1'b0;
            wl_q <= 1'b0;
            last_status_q <= 8'h00;
        end else begin
            nv_start_q <= 1'b0;
            if (stop_c) begin
                // stop after data launches the write unless protect, lock or alarm and time guards block it
                if (do_commit) begin
                    nv_start_q <= 1'b1;
                    if (is_status) begin
                        wl_q <= (last_status_q == UNLOCK_1)
                                & (status_new == UNLOCK_2);
                        last_status_q <= status_new;
                    end
                end
                // stop after word address keeps loaded counter
                state_q <= ST_IDLE;
                sda_oe_q <= 1'b0;
                pvalid_q <= 16'h0000;
            end else if (start_c & ~busy) begin
                state_q <= ST_ADDR;
                bit_q <= 4'h0;
                ack_phase_q <= 1'b0;
                sda_oe_q <= 1'b0;
                nbytes_q <= 5'h00;
                pvalid_q <= 16'h0000;
            end else if (scl_rise & ~ack_phase_q & (state_q != ST_IDLE)
                         & (state_q != ST_RDATA)) begin
                sh_q <= byte_in;
                bit_q <= bit_q + 4'h1;
            end else if (scl_rise & ack_phase_q & (state_q == ST_RACK)) begin
                data_ack_q <= ~sda_s;
            end else if (scl_fall) begin
                if (ack_phase_q) begin
                    ack_phase_q <= 1'b0;
                    sda_oe_q <= 1'b0;
                    bit_q <= 4'h0;
                    if (state_q == ST_RACK) begin
                        // continue on acknowledge, wrap whole space
                        if (data_ack_q) begin
                            addr_q <= nxt_addr;
                            state_q <= ST_RDATA;
                            sda_oe_q <= ~rd_next[7];
                            bit_q <= 4'h1;
                        end else begin
                            addr_q <= seq_inc(addr_q, regs_sel_q);
                            state_q <= ST_IDLE;
                        end
                    end else if (state_q == ST_RDATA) begin
                        // first data bit from counter location
                        sda_oe_q <= ~rd_byte[7];
                        bit_q <= 4'h1;
                    end
                end else if (state_q == ST_RDATA) begin
                    if (bit_q == 4'h8) begin
                        sda_oe_q <= 1'b0;
                        state_q <= ST_RACK;
                        ack_phase_q <= 1'b1;
                    end else begin
                        sda_oe_q <= ~rd_byte[3'(4'h7 - bit_q)];
                        bit_q <= bit_q + 4'h1;
                    end
                end else if (bit_q == 4'h8) begin
                    case (state_q)
                        ST_ADDR: begin
                            if (addr_match) begin
                                ack_phase_q <= 1'b1;
                                sda_oe_q <= 1'b1;
                                if (sh_q[0]) begin
                                    // target stays as the master names it
                                    regs_sel_q <= (sh_q[7:4] == REGS_ID);
                                    state_q <= ST_RDATA;
                                end else begin
                                    regs_sel_q <= (sh_q[7:4] == REGS_ID);
                                    state_q <= ST_WADDR_HI;
                                end
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                        ST_WADDR_HI: begin
                            addr_q[15:8] <= sh_q;
                            ack_phase_q <= 1'b1;
                            sda_oe_q <= 1'b1;
                            state_q <= ST_WADDR_LO;
                        end
                        ST_WADDR_LO: begin
                            addr_q[7:0] <= sh_q;
                            wbase_q <= {addr_q[15:8], sh_q};
                            ack_phase_q <= 1'b1;
                            sda_oe_q <= 1'b1;
                            state_q <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            // later bytes overwrite the wrapped slot
                            pbuf[slot] <= sh_q;
                            pvalid_q[slot] <= 1'b1;
                            wbase_q <= addr_q;
                            addr_q <= page_inc(addr_q, regs_sel_q);
                            if (nbytes_q < page_len) begin
                                nbytes_q <= nbytes_q + 5'h01;
                            end
                            ack_phase_q <= 1'b1;
                            sda_oe_q <= 1'b1;
                        end
                        default: state_q <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // Array and register stores from the page buffer at commit
    wire [15:0] page_base = regs_sel_q ? {wbase_q[15:3], 3'h0} : {wbase_q[15:4], 4'h0};
    // One process owns each memory, so no slot has two drivers
    always_ff @(posedge mclk) begin
        if (stop_c & do_commit) begin
            for (int i = 0; i < 16; i++) begin
                if (pvalid_q[i]) begin
                    if (regs_sel_q) begin
                        if (i < 8) begin
                            regs_mem[page_base[REGS_AW-1:0] | 6'(i)] <= pbuf[i];
                        end
                    end else begin
                        array_mem[page_base[ARRAY_AW-1:0] | 9'(i)] <= pbuf[i];
                    end
                end
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_q;
    assign nv_busy = busy;

    a_busy_no_ack: assert property (@(posedge mclk) disable iff (!arst_n)
        (busy && state_q == ST_IDLE) |-> !sda_oe_q)
        else $error("drive seen during write cycle");
    a_short_stop: assert property (@(posedge mclk) disable iff (!arst_n)
        (stop_c && nbytes_q == 5'h00) |=> !nv_start_q)
        else $error("write launched without data");
    a_launch_busy: assert property (@(posedge mclk) disable iff (!arst_n)
        nv_start_q |=> busy)
        else $error("write cycle not busy after launch");
    a_protect_skip: assert property (@(posedge mclk) disable iff (!arst_n)
        (stop_c && prot_hit) |=> !nv_start_q)
        else $error("protected write launched");
    a_alarm_single: assert property (@(posedge mclk) disable iff (!arst_n)
        (stop_c && alarm_single) |=> !nv_start_q)
        else $error("single alarm byte launched");
    a_mismatch_free: assert property (@(posedge mclk) disable iff (!arst_n)
        (scl_fall && state_q == ST_ADDR && bit_q == 4'h8 && !addr_match) |=> !sda_oe_q)
        else $error("drive after mismatched address");
    a_page_wrap: assert property (@(posedge mclk) disable iff (!arst_n)
        (scl_fall && state_q == ST_WDATA && bit_q == 4'h8 && !ack_phase_q && !regs_sel_q)
        |=> addr_q[15:4] == $past(addr_q[15:4]))
        else $error("write address left its page");
    a_reset_zero: assert property (@(posedge mclk)
        $rose(arst_n) |-> addr_q == ADDR_RESET)
        else $error("address counter not zero after reset");
    // start ignored during the write cycle
    a_busy_ignore: assert property (@(posedge mclk) disable iff (!arst_n)
        (busy && start_c && state_q == ST_IDLE) |=> state_q == ST_IDLE)
        else $error("start taken during write cycle");
    // stop after the word address keeps the counter
    a_set_addr: assert property (@(posedge mclk) disable iff (!arst_n)
        (stop_c && state_q == ST_WDATA && nbytes_q == 5'h00) |=> addr_q == $past(addr_q))
        else $error("counter moved by address-only stop");
endmodule : rsa_serial_access
`default_nettype wire

/* verilog/rsa_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two flip-flop synchroniser for one pin
module rsa_sync (
    input wire logic mclk,   // System clock
    input wire logic arst_n, // Async reset
    input wire logic din,    // Pin level
    output logic dout        // Synchronised level
);
    logic meta_q;
    // Two stages, idle high like the bus
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : rsa_sync
`default_nettype wire
